/* File: design/pcss_regs.sv */
`timescale 1ns/1ns
// Functional notes
// - status bit 7 always reads zero
// - status bit 6 shows socket power on, following power control programming
// - status bit 5 shows live card ready input
// - status bit 4 mirrors card write-protect input
// - status bits 3 and 2 show the inverted card detect pins
// - memory card: bit 1 second battery detect, bit 0 first
// - I/O card: bit 1 audio out, bit 0 status change, undecoded
// - card kind bit in general control: 0 memory (default), 1 I/O
// - after reset status bits 7:6 are zero, others follow the pins
// - legacy and extended power layouts, chosen by revision field
// - revision field 0010b selects the legacy layout
// - power bit 7 enables card outputs, resets to 0
// - legacy: bit 6 and bits 3:2 read zero, writes ignored
// - legacy: bit 5 enables detect-driven automatic power switching
// - legacy: bit 4 enables Vcc at the level from system control
// - bits 1:0 request Vpp; ignored while Vcc is off
// - extended: bits 4:3 request Vcc: 0 V, 0 V, 5 V, 3.3 V
// - extended: bits 6:5 and bit 2 read zero, not writable
// - writes through a write-protected memory window are blocked
// - power control register resets to zero
module pcss_regs
#(
	parameter int WIN_COUNT = pcss_pkg::WIN_COUNT
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire pcss_pkg::pcss_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire pcss_pkg::pcss_card_pins_t card_pins_i,
	input wire logic supply_level_select_i,
	input wire logic [WIN_COUNT-1:0] win_write_protect_i,
	input wire logic [WIN_COUNT-1:0] win_hit_i,
	input wire logic card_write_req_i,
	output logic card_write_allow_o,
	output pcss_pkg::pcss_power_t power_o
);

	// writable bits of the power register in the active layout
	function automatic logic [7:0] power_mask(input logic legacy);
		power_mask = legacy ? pcss_pkg::PW_MASK_LEGACY : pcss_pkg::PW_MASK_EXT;
	endfunction

	// one write strobe decode shared by every writable register and some of its checks
	function automatic logic write_hit(input pcss_pkg::pcss_reg_req_t req, input logic [5:0] ofs);
		write_hit = req.wr && req.addr == ofs;
	endfunction

	function automatic logic read_hit(input pcss_pkg::pcss_reg_req_t req, input logic [5:0] ofs);
		read_hit = req.rd && req.addr == ofs;
	endfunction

	logic [5:0] pin_meta_r;
	logic [5:0] pin_sync_r;
	logic [7:0] ident_r;
	logic [7:0] power_r;
	logic [7:0] genctl_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic write_allow_r;
	pcss_pkg::pcss_power_t power_out_r;
	pcss_pkg::pcss_card_pins_t pins_s;
	logic legacy_w;
	logic io_card_w;
	logic cards_seated_w;
	logic [1:0] vcc_req_w;
	logic power_on_w;
	logic [7:0] power_rd_w;
	logic [7:0] status_w;
	logic [7:0] rd_mux_w;

	// two-stage synchronisers for every card pin
	genvar gi;
	generate
		for (gi = 0; gi < $bits(pcss_pkg::pcss_card_pins_t); gi++)
		begin : g_sync
			always_ff @(posedge mclk_i)
			begin
				if (rst_i)
				begin
					pin_meta_r[gi] <= 1'b0;
					pin_sync_r[gi] <= 1'b0;
				end
				else if (ce_i)
				begin
					pin_meta_r[gi] <= card_pins_i[gi];
					pin_sync_r[gi] <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	assign pins_s = pcss_pkg::pcss_card_pins_t'(pin_sync_r);

	// identification register: top two bits hardwired
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ident_r <= pcss_pkg::RST_IDENT;
		else if (ce_i && write_hit(reg_req_i, pcss_pkg::OFS_IDENT))
			ident_r <= {pcss_pkg::IDENT_IFTYPE, reg_req_i.wdata[5:0]};
	end

	assign legacy_w = ident_r[pcss_pkg::REV_LSB +: 4] == pcss_pkg::REV_LEGACY;

	// general control register, only card kind is used here
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			genctl_r <= pcss_pkg::RST_GENCTL;
		else if (ce_i && write_hit(reg_req_i, pcss_pkg::OFS_GENCTL))
			genctl_r <= reg_req_i.wdata;
	end

	assign io_card_w = genctl_r[pcss_pkg::CARD_KIND_BIT];

	// power control: bits outside the layout mask are dropped on write
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			power_r <= pcss_pkg::RST_POWER;
		else if (ce_i && write_hit(reg_req_i, pcss_pkg::OFS_POWER))
			power_r <= reg_req_i.wdata & power_mask(legacy_w);
	end

	// stale bits from the other layout are masked on read as well
	assign power_rd_w = power_r & power_mask(legacy_w);

	assign cards_seated_w = ~pins_s.detect_a_pin_n & ~pins_s.detect_b_pin_n;

	// supply request in either layout
	always_comb
	begin
		vcc_req_w = pcss_pkg::VCC_OFF;
		if (legacy_w)
		begin
			if (power_rd_w[pcss_pkg::PW_SUPPLY_EN_BIT]
				&& (!power_rd_w[pcss_pkg::PW_AUTO_BIT] || cards_seated_w))
				vcc_req_w = supply_level_select_i ? pcss_pkg::VCC_3V3 : pcss_pkg::VCC_5V;
		end
		else
		begin
			case (power_rd_w[pcss_pkg::PW_VCC_LSB +: 2])
				pcss_pkg::VCC_5V: vcc_req_w = pcss_pkg::VCC_5V;
				pcss_pkg::VCC_3V3: vcc_req_w = pcss_pkg::VCC_3V3;
				default: vcc_req_w = pcss_pkg::VCC_OFF;
			endcase
		end
	end

	assign power_on_w = vcc_req_w != pcss_pkg::VCC_OFF;

	// status composition; pins are live, bit 6 comes from the supply request and bit 7 is zero
	always_comb
	begin
		status_w = 8'h00;
		status_w[pcss_pkg::ST_PWR_BIT] = power_on_w;
		status_w[pcss_pkg::ST_READY_BIT] = pins_s.ready;
		status_w[pcss_pkg::ST_WP_BIT] = pins_s.write_protect;
		status_w[pcss_pkg::ST_DET_B_BIT] = ~pins_s.detect_b_pin_n;
		status_w[pcss_pkg::ST_DET_A_BIT] = ~pins_s.detect_a_pin_n;
		// the audio and status-change outputs share the battery detect pins
		status_w[1] = pins_s.battery_detect_b;
		status_w[0] = pins_s.battery_detect_a;
	end

	always_comb
	begin
		case (reg_req_i.addr)
			pcss_pkg::OFS_IDENT: rd_mux_w = ident_r;
			pcss_pkg::OFS_STATUS: rd_mux_w = status_w;
			pcss_pkg::OFS_POWER: rd_mux_w = power_rd_w;
			pcss_pkg::OFS_GENCTL: rd_mux_w = genctl_r;
			default: rd_mux_w = 8'h00;
		endcase
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else if (ce_i)
		begin
			rvalid_r <= reg_req_i.rd;
			if (reg_req_i.rd)
				rdata_r <= rd_mux_w;
		end
	end

	// registered socket power outputs
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			power_out_r <= '0;
		else if (ce_i)
		begin
			power_out_r.card_output_enable <= power_rd_w[pcss_pkg::PW_COE_BIT];
			power_out_r.auto_socket_power_switch_en <= legacy_w & power_rd_w[pcss_pkg::PW_AUTO_BIT];
			power_out_r.supply_voltage_request <= vcc_req_w;
			// Vpp follows the request only while Vcc is applied
			power_out_r.prog_voltage_request <= power_on_w ? power_rd_w[pcss_pkg::PW_VPP_LSB +: 2]
				: pcss_pkg::VPP_NONE;
		end
	end

	// window write protection; a hit on any protected window blocks
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			write_allow_r <= 1'b0;
		else if (ce_i)
			write_allow_r <= card_write_req_i && ((win_hit_i & win_write_protect_i) == '0);
	end

	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign power_o = power_out_r;
	assign card_write_allow_o = write_allow_r;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// status bit 7 zero and bit 6 tied to the supply request
	status_top_a: assert property ((ce_i && reg_req_i.rd && reg_req_i.addr == pcss_pkg::OFS_STATUS)
		|=> (!reg_rdata_o[7] && reg_rdata_o[6] == $past(power_on_w)))
		else $error("status bits 7:6 wrong");

	power_flag_a: assert property (power_on_w == (vcc_req_w == pcss_pkg::VCC_5V || vcc_req_w == pcss_pkg::VCC_3V3))
		else $error("power flag disagrees with supply request");

	status_pins_a: assert property ((ce_i && reg_req_i.rd && reg_req_i.addr == pcss_pkg::OFS_STATUS)
		|=> reg_rdata_o[5:2] == $past({pins_s.ready, pins_s.write_protect,
			~pins_s.detect_b_pin_n, ~pins_s.detect_a_pin_n}))
		else $error("status pin bits wrong");

	status_battery_a: assert property ((ce_i && reg_req_i.rd && reg_req_i.addr == pcss_pkg::OFS_STATUS)
		|=> reg_rdata_o[1:0] == $past({pins_s.battery_detect_b, pins_s.battery_detect_a}))
		else $error("battery or audio field wrong");

	vpp_gated_a: assert property ((ce_i && !power_on_w) |=> power_o.prog_voltage_request == pcss_pkg::VPP_NONE)
		else $error("Vpp requested without Vcc");

	legacy_rsvd_a: assert property ((ce_i && legacy_w && reg_req_i.rd && reg_req_i.addr == pcss_pkg::OFS_POWER)
		|=> (reg_rdata_o[6] == 1'b0 && reg_rdata_o[3:2] == 2'b00))
		else $error("legacy reserved power bits not zero");

	ext_rsvd_a: assert property ((ce_i && !legacy_w && reg_req_i.rd && reg_req_i.addr == pcss_pkg::OFS_POWER)
		|=> (reg_rdata_o[6:5] == 2'b00 && reg_rdata_o[2] == 1'b0))
		else $error("extended reserved power bits not zero");

	legacy_sel_a: assert property ((ce_i && reg_req_i.wr && reg_req_i.addr == pcss_pkg::OFS_IDENT
		&& reg_req_i.wdata[3:0] == pcss_pkg::REV_LEGACY) |=> legacy_w)
		else $error("revision write did not select legacy layout");

	ext_vcc_a: assert property ((!legacy_w && power_r[4:3] == pcss_pkg::VCC_OFF_RSVD) |-> !power_on_w)
		else $error("reserved Vcc code applied power");

	coe_out_a: assert property (ce_i |=> power_o.card_output_enable == $past(power_r[pcss_pkg::PW_COE_BIT]))
		else $error("card output enable not following bit 7");

	wp_block_a: assert property ((ce_i && (win_hit_i & win_write_protect_i) != '0) |=> !card_write_allow_o)
		else $error("write through protected window allowed");

	write_open_a: assert property ((ce_i && card_write_req_i && (win_hit_i & win_write_protect_i) == '0)
		|=> card_write_allow_o)
		else $error("unprotected card write blocked");

	write_idle_a: assert property ((ce_i && !card_write_req_i) |=> !card_write_allow_o)
		else $error("card write allowed without request");

	card_kind_a: assert property ((ce_i && write_hit(reg_req_i, pcss_pkg::OFS_GENCTL))
		|=> io_card_w == $past(reg_req_i.wdata[pcss_pkg::CARD_KIND_BIT]))
		else $error("card kind bit not stored");

	status_io_a: assert property ((ce_i && io_card_w && read_hit(reg_req_i, pcss_pkg::OFS_STATUS))
		|=> reg_rdata_o[1:0] == $past({pins_s.battery_detect_b, pins_s.battery_detect_a}))
		else $error("audio or status change field wrong");

	layout_ext_a: assert property ((ce_i && write_hit(reg_req_i, pcss_pkg::OFS_IDENT)
		&& reg_req_i.wdata[3:0] != pcss_pkg::REV_LEGACY) |=> !legacy_w)
		else $error("revision write did not select extended layout");

	legacy_wr_a: assert property ((ce_i && legacy_w && write_hit(reg_req_i, pcss_pkg::OFS_POWER))
		|=> (power_r[6] == 1'b0 && power_r[3:2] == 2'b00))
		else $error("legacy reserved power bits stored");

	ext_wr_a: assert property ((ce_i && !legacy_w && write_hit(reg_req_i, pcss_pkg::OFS_POWER))
		|=> (power_r[6:5] == 2'b00 && power_r[2] == 1'b0))
		else $error("extended reserved power bits stored");

	ext_auto_a: assert property ((ce_i && !legacy_w) |=> !power_o.auto_socket_power_switch_en)
		else $error("auto switch active in extended layout");

	legacy_vcc_a: assert property ((ce_i && legacy_w && power_r[pcss_pkg::PW_SUPPLY_EN_BIT]
		&& (!power_r[pcss_pkg::PW_AUTO_BIT] || !(pins_s.detect_a_pin_n || pins_s.detect_b_pin_n)))
		|=> power_o.supply_voltage_request
			== ($past(supply_level_select_i) ? pcss_pkg::VCC_3V3 : pcss_pkg::VCC_5V))
		else $error("legacy supply level wrong");

	legacy_auto_off_a: assert property ((ce_i && legacy_w && power_r[pcss_pkg::PW_AUTO_BIT]
		&& (pins_s.detect_a_pin_n || pins_s.detect_b_pin_n)) |=> power_o.supply_voltage_request == pcss_pkg::VCC_OFF)
		else $error("auto switch kept supply on an empty socket");

	ext_vcc_map_a: assert property ((ce_i && !legacy_w)
		|=> power_o.supply_voltage_request
			== ($past(power_r[4]) ? $past(power_r[4:3]) : pcss_pkg::VCC_OFF))
		else $error("extended supply code not applied");

	vpp_pass_a: assert property ((ce_i && power_on_w)
		|=> power_o.prog_voltage_request == $past(power_r[pcss_pkg::PW_VPP_LSB +: 2]))
		else $error("Vpp request not passed while Vcc on");

	supply_flag_a: assert property (ce_i |=> ((power_o.supply_voltage_request != pcss_pkg::VCC_OFF) == $past(power_on_w)))
		else $error("supply output disagrees with power flag");

	// reset edges must be checked too, so these override the default disable
	reset_power_a: assert property (disable iff (1'b0) rst_i
		|=> (power_r == pcss_pkg::RST_POWER && power_o == '0 && !card_write_allow_o))
		else $error("power control not cleared by reset");

	reset_status_a: assert property (disable iff (1'b0) rst_i |=> status_w[7:6] == 2'b00)
		else $error("status bits 7:6 not zero after reset");

	// two edges of latency through the pin synchronisers
	pin_sync_a: assert property ((ce_i ##1 ce_i) |=> pins_s == $past(card_pins_i, 2))
		else $error("card pins not synchronised in two cycles");

	io_card_c: cover property (io_card_w && reg_rvalid_o);
	legacy_on_c: cover property (legacy_w && power_o.supply_voltage_request != pcss_pkg::VCC_OFF);
	ext_vpp_c: cover property (!legacy_w && power_o.prog_voltage_request != pcss_pkg::VPP_NONE);
	wp_hit_c: cover property (card_write_req_i && !card_write_allow_o && ce_i);
	auto_drop_c: cover property (power_o.auto_socket_power_switch_en && power_o.supply_voltage_request == pcss_pkg::VCC_OFF);

endmodule

/* File: design/pcss_pkg.sv */
package pcss_pkg;

	// register offsets in the socket register space
	localparam logic [5:0] OFS_IDENT = 6'h00;
	localparam logic [5:0] OFS_STATUS = 6'h01;
	localparam logic [5:0] OFS_POWER = 6'h02;
	localparam logic [5:0] OFS_GENCTL = 6'h03;

	// reset values
	localparam logic [7:0] RST_IDENT = 8'h84;
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_GENCTL = 8'h00;

	// identification register fields
	localparam logic [1:0] IDENT_IFTYPE = 2'h2;
	localparam logic [3:0] REV_LEGACY = 4'h2;
	localparam int REV_LSB = 0;
	localparam int IFTYPE_LSB = 6;

	// general control field
	localparam int CARD_KIND_BIT = 5;

	// status register fields
	localparam int ST_PWR_BIT = 6;
	localparam int ST_READY_BIT = 5;
	localparam int ST_WP_BIT = 4;
	localparam int ST_DET_B_BIT = 3;
	localparam int ST_DET_A_BIT = 2;

	// power control fields
	localparam int PW_COE_BIT = 7;
	localparam int PW_AUTO_BIT = 5;
	localparam int PW_SUPPLY_EN_BIT = 4;
	localparam int PW_VCC_LSB = 3;
	localparam int PW_VPP_LSB = 0;

	// writable masks of the two power control layouts
	localparam logic [7:0] PW_MASK_LEGACY = 8'hB3;
	localparam logic [7:0] PW_MASK_EXT = 8'h9B;

	// supply voltage request codes
	localparam logic [1:0] VCC_OFF = 2'h0;
	localparam logic [1:0] VCC_OFF_RSVD = 2'h1;
	localparam logic [1:0] VCC_5V = 2'h2;
	localparam logic [1:0] VCC_3V3 = 2'h3;

	// programming voltage request codes
	localparam logic [1:0] VPP_NONE = 2'h0;

	localparam int WIN_COUNT = 5;

	typedef struct packed {
		logic ready;
		logic write_protect;
		logic detect_b_pin_n;
		logic detect_a_pin_n;
		logic battery_detect_b;
		logic battery_detect_a;
	} pcss_card_pins_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} pcss_reg_req_t;

	typedef struct packed {
		logic card_output_enable;
		logic auto_socket_power_switch_en;
		logic [1:0] supply_voltage_request;
		logic [1:0] prog_voltage_request;
	} pcss_power_t;

endpackage

/* File: verification/pcss_card_model.sv */
`timescale 1ns/1ns
module pcss_card_model
(
	input wire logic inserted_i,
	input wire logic [3:0] state_i,
	output pcss_pkg::pcss_card_pins_t pins_o
);
	// detect lines carry pull-ups, so an empty socket reads both high
	// other card lines float to their pull-down level when no card sits
	assign pins_o = inserted_i ? {state_i[3:2], 2'b00, state_i[1:0]} : 6'h0C;
endmodule

/* File: verification/pcss_regs_tb.sv */
`timescale 1ns/1ns
module pcss_regs_tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	pcss_pkg::pcss_reg_req_t req = '0;
	logic [7:0] rdata;
	logic rvalid;
	pcss_pkg::pcss_card_pins_t pins;
	logic sel = 1'b0;
	logic [4:0] wwp = 5'h00;
	logic [4:0] whit = 5'h00;
	logic wreq = 1'b0;
	logic allow;
	pcss_pkg::pcss_power_t pwr;
	logic ins = 1'b0;
	logic [3:0] cst = 4'h0;
	logic [7:0] got;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	pcss_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_req_i(req), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .card_pins_i(pins), .supply_level_select_i(sel), .win_write_protect_i(wwp),
		.win_hit_i(whit), .card_write_req_i(wreq), .card_write_allow_o(allow), .power_o(pwr));
	pcss_card_model card (.inserted_i(ins), .state_i(cst), .pins_o(pins));

	initial
	begin
		forever #20 mclk_i = ~mclk_i;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge mclk_i)
	begin
		cycles++;
		// whole run needs well under a thousand cycles
		if (cycles == 4000)
		begin
			fails++;
			wrap_up();
		end
	end

	task automatic check8(input logic [7:0] act, input logic [7:0] exp);
		tests_run++;
		if (act !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0h got=%h exp=%h", $time, act, exp);
		end
	endtask

	task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge mclk_i);
		req.wr = 1'b0;
		repeat (2) @(negedge mclk_i);
	endtask

	task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk_i);
		req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge mclk_i);
		req.rd = 1'b0;
		while (rvalid !== 1'b1 && n < 4)
		begin
			@(negedge mclk_i);
			n++;
		end
		check8({7'h00, rvalid}, 8'h01);
		d = rdata;
	endtask

	task automatic sc_reset();
		reg_rd(pcss_pkg::OFS_POWER, got);
		check8(got, 8'h00);
		check8({2'b00, pwr}, 8'h00);
		reg_rd(pcss_pkg::OFS_STATUS, got);
		check8(got, 8'h00);
		reg_rd(6'h3F, got);
		check8(got, 8'h00);
	endtask

	task automatic sc_status();
		ins = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			cst = i[3:0];
			repeat (4) @(negedge mclk_i);
			reg_rd(pcss_pkg::OFS_STATUS, got);
			check8(got, {2'b00, cst[3:2], 2'b11, cst[1:0]});
		end
		reg_wr(pcss_pkg::OFS_GENCTL, 8'h20);
		reg_rd(pcss_pkg::OFS_GENCTL, got);
		check8(got, 8'h20);
		cst = 4'h2;
		repeat (4) @(negedge mclk_i);
		reg_rd(pcss_pkg::OFS_STATUS, got);
		check8(got, 8'h0E);
	endtask

	task automatic sc_ext();
		logic [1:0] v;
		for (int c = 0; c < 4; c++)
		begin
			reg_wr(pcss_pkg::OFS_POWER, {3'b111, c[1:0], 3'b111});
			reg_rd(pcss_pkg::OFS_POWER, got);
			check8(got, {3'b100, c[1:0], 3'b011});
			v = (c == 1) ? 2'b00 : c[1:0];
			check8({2'b00, pwr}, {4'b0010, v, (v != 2'b00) ? 2'b11 : 2'b00});
			reg_rd(pcss_pkg::OFS_STATUS, got);
			check8({7'h00, got[6]}, {7'h00, v != 2'b00});
		end
	endtask

	task automatic sc_legacy();
		reg_wr(pcss_pkg::OFS_IDENT, 8'h02);
		reg_rd(pcss_pkg::OFS_IDENT, got);
		check8(got, 8'h82);
		reg_wr(pcss_pkg::OFS_POWER, 8'hFF);
		reg_rd(pcss_pkg::OFS_POWER, got);
		check8(got, 8'hB3);
		check8({2'b00, pwr}, 8'h3B);
		sel = 1'b1;
		repeat (2) @(negedge mclk_i);
		check8({2'b00, pwr}, 8'h3F);
		// pulled card must drop supply through the auto switch
		ins = 1'b0;
		repeat (5) @(negedge mclk_i);
		check8({2'b00, pwr}, 8'h30);
		ins = 1'b1;
		reg_wr(pcss_pkg::OFS_POWER, 8'h01);
		repeat (4) @(negedge mclk_i);
		check8({2'b00, pwr}, 8'h00);
		reg_rd(pcss_pkg::OFS_STATUS, got);
		check8({7'h00, got[6]}, 8'h00);
		reg_wr(pcss_pkg::OFS_IDENT, 8'h84);
	endtask

	task automatic sc_guard();
		wwp = 5'h04;
		whit = 5'h04;
		wreq = 1'b1;
		repeat (2) @(negedge mclk_i);
		check8({7'h00, allow}, 8'h00);
		whit = 5'h02;
		repeat (2) @(negedge mclk_i);
		check8({7'h00, allow}, 8'h01);
		wreq = 1'b0;
	endtask

	task automatic sc_midreset();
		reg_wr(pcss_pkg::OFS_POWER, 8'h9B);
		check8({2'b00, pwr}, 8'h2F);
		rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		rst_i = 1'b0;
		check8({2'b00, pwr}, 8'h00);
		reg_rd(pcss_pkg::OFS_POWER, got);
		check8(got, 8'h00);
		reg_rd(pcss_pkg::OFS_GENCTL, got);
		check8(got, 8'h00);
		reg_rd(pcss_pkg::OFS_STATUS, got);
		check8(got, 8'h0E);
	endtask

	initial
	begin
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		sc_reset();
		sc_status();
		sc_ext();
		sc_legacy();
		sc_guard();
		sc_midreset();
		wrap_up();
	end
endmodule
